// file: design/fcs_host.sv
// Purpose: AHB-Lite driven host that issues flash command sequences
// Assumes: flash pins sampled synchronously to ref_clk
// Notes:   one flash bus cycle = address, strobe low, strobe high
`default_nettype none
module fcs_host #(
  parameter int ADDR_W = 22
) (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              clk_en,
  // ahb-lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic      [31:0]       hrdata,
  // flash pins
  output logic      [ADDR_W-1:0] flash_addr,
  output logic                   chip_select_n,
  output logic                   write_strobe_n,
  output logic                   output_enable_n,
  output logic      [7:0]        flash_dq_out,
  output logic                   flash_dq_oe,
  input  wire logic [7:0]        flash_dq_in,
  input  wire logic              ready_busy_n
);
  // bus sequencer states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_FETCH = 3'b001,
    ST_SETUP = 3'b010,
    ST_PULSE = 3'b011,
    ST_HOLD  = 3'b100
  } fcs_state_t;

  fcs_state_t        state;      // sequencer state
  logic [3:0]        op;         // command in progress
  logic [2:0]        step;       // step index in sequence
  logic [3:0]        tcnt;       // strobe phase counter
  logic [ADDR_W-1:0] user_addr;  // software target address
  logic [7:0]        user_data;  // software program byte
  logic [7:0]        rd_byte;    // last byte read
  logic [7:0]        prev_byte;  // byte read before it
  logic              seq_busy;   // command being issued
  logic              cmd_err;    // refusal flag, cleared at command start, never set
  logic [33:0]       entry;      // current step word
  // ahb address phase capture
  logic              ph_wr;
  logic              ph_rd;
  logic [7:0]        ph_addr;

  // step table
  fcs_seq_rom u_rom (
    .ref_clk (ref_clk),
    .clk_en  (clk_en),
    .op      (op),
    .step    (step),
    .entry   (entry)
  );

  // fields of the step word
  wire logic        e_last = entry[33];
  wire logic        e_rd   = entry[32];
  wire logic        e_ua   = entry[31];
  wire logic        e_ud   = entry[30];
  wire logic [21:0] e_addr = entry[29:8];
  wire logic [7:0]  e_data = entry[7:0];

  // register offset matcher
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction

  wire logic xfer = hsel & hready & htrans[1];

  // address phase capture, always ready
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ph_wr   <= 1'b0;
      ph_rd   <= 1'b0;
      ph_addr <= 8'h00;
    end else if (clk_en && hready) begin
      ph_wr   <= xfer & hwrite;
      ph_rd   <= xfer & ~hwrite;
      ph_addr <= haddr[7:0];
    end
  end

  // zero wait state answer, OKAY only
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else if (clk_en) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // read data mux, registered one cycle early
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      hrdata <= 32'h00000000;
    end else if (clk_en && xfer && !hwrite) begin
      case (haddr[7:0])
        fcs_pkg::REG_CMD:    hrdata <= {28'h0000000, op};
        fcs_pkg::REG_ADDR:   hrdata <= {{(32-ADDR_W){1'b0}}, user_addr};
        fcs_pkg::REG_DATA:   hrdata <= {24'h000000, user_data};
        fcs_pkg::REG_STATUS: hrdata <= {27'h0000000, ~ready_busy_n,
                                        cmd_err, 2'b00, seq_busy};
        fcs_pkg::REG_RDATA:  hrdata <= {16'h0000, prev_byte, rd_byte};
        default:             hrdata <= 32'h00000000;
      endcase
    end
  end

  // software parameter registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      user_addr <= '0;
      user_data <= 8'h00;
    end else if (clk_en && ph_wr) begin
      if (hit(ph_addr, fcs_pkg::REG_ADDR))
        user_addr <= hwdata[ADDR_W-1:0];
      if (hit(ph_addr, fcs_pkg::REG_DATA))
        user_data <= hwdata[7:0];
    end
  end

  // command start and the flash bus sequencer
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state           <= ST_IDLE;
      op              <= fcs_pkg::OP_READ;
      step            <= 3'd0;
      tcnt            <= 4'h0;
      seq_busy        <= 1'b0;
      cmd_err         <= 1'b0;
      flash_addr      <= '0;
      chip_select_n   <= 1'b1;
      write_strobe_n  <= 1'b1;
      output_enable_n <= 1'b1;
      flash_dq_out    <= 8'h00;
      flash_dq_oe     <= 1'b0;
      rd_byte         <= 8'h00;
      prev_byte       <= 8'h00;
    end else if (clk_en) begin
      case (state)
        ST_IDLE: begin
          if (ph_wr && hit(ph_addr, fcs_pkg::REG_CMD)) begin
            op       <= hwdata[3:0];
            step     <= (hwdata[3:0] == fcs_pkg::OP_READ ||
                         hwdata[3:0] == fcs_pkg::OP_RESET ||
                         hwdata[3:0] == fcs_pkg::OP_SUSPEND ||
                         hwdata[3:0] == fcs_pkg::OP_RESUME ||
                         hwdata[3:0] == fcs_pkg::OP_SECT_ADD)
                        ? 3'd7 : 3'd0;
            seq_busy <= 1'b1;
            cmd_err  <= 1'b0;
            state    <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          // wait one cycle for the registered step word
          tcnt  <= 4'h0;
          state <= ST_SETUP;
        end
        ST_SETUP: begin
          // upper address bits zero on unlocks
          flash_addr    <= e_ua ? user_addr : e_addr[ADDR_W-1:0];
          flash_dq_out  <= e_ud ? user_data : e_data;
          flash_dq_oe   <= ~e_rd;
          chip_select_n <= 1'b0;
          tcnt          <= tcnt + 4'h1;
          if (tcnt == 4'h1) begin
            tcnt  <= 4'h0;
            state <= ST_PULSE;
          end
        end
        ST_PULSE: begin
          // autoselect fourth cycle is a read
          write_strobe_n  <= e_rd;
          output_enable_n <= ~e_rd;
          tcnt            <= tcnt + 4'h1;
          if (tcnt == fcs_pkg::STROBE_CYC) begin
            // each read sampled for toggle compare
            // two reads kept, software picks later one
            if (e_rd) begin
              prev_byte <= rd_byte;
              rd_byte   <= flash_dq_in;
            end
            tcnt  <= 4'h0;
            state <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          write_strobe_n  <= 1'b1;
          output_enable_n <= 1'b1;
          tcnt            <= tcnt + 4'h1;
          if (tcnt == 4'h2) begin
            chip_select_n <= 1'b1;
            flash_dq_oe   <= 1'b0;
            tcnt          <= 4'h0;
            if (e_last) begin
              // status polled only after last strobe
              seq_busy <= 1'b0;
              state    <= ST_IDLE;
            end else begin
              step  <= step + 3'd1;
              state <= ST_FETCH;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// file: pkg/fcs_pkg.sv
// Purpose: constants for the flash command host controller
// Assumes: byte-wide asynchronous flash, 22-bit address
// Notes:   offsets are byte addresses of the controller registers
`default_nettype none
package fcs_pkg;
  // controller register byte offsets
  localparam logic [7:0] REG_CMD    = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_DATA   = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_RDATA  = 8'h10;
  // command codes written to REG_CMD
  localparam logic [3:0] OP_READ    = 4'h1;
  localparam logic [3:0] OP_RESET   = 4'h2;
  localparam logic [3:0] OP_AUTOSEL = 4'h3;
  localparam logic [3:0] OP_PROGRAM = 4'h4;
  localparam logic [3:0] OP_CHIP_ER = 4'h5;
  localparam logic [3:0] OP_SECT_ER = 4'h6;
  localparam logic [3:0] OP_SUSPEND = 4'h7;
  localparam logic [3:0] OP_RESUME  = 4'h8;
  localparam logic [3:0] OP_SECT_ADD = 4'h9;
  // flash bus cycle addresses and data
  localparam logic [21:0] UNLOCK_A1 = 22'h000555;
  localparam logic [21:0] UNLOCK_A2 = 22'h0002AA;
  localparam logic [7:0]  UNLOCK_D1 = 8'hAA;
  localparam logic [7:0]  UNLOCK_D2 = 8'h55;
  localparam logic [7:0]  CD_PROG   = 8'hA0;
  localparam logic [7:0]  CD_ERSET  = 8'h80;
  localparam logic [7:0]  CD_CHIP   = 8'h10;
  localparam logic [7:0]  CD_SECT   = 8'h30;
  localparam logic [7:0]  CD_AUTO   = 8'h90;
  localparam logic [7:0]  CD_RESET  = 8'hF0;
  localparam logic [7:0]  CD_SUSP   = 8'hB0;
  localparam logic [7:0]  CD_RESUME = 8'h30;
  // status bit positions on the data bus
  localparam int POLL_POS  = 7;
  localparam int TOG1_POS  = 6;
  localparam int FAIL_POS  = 5;
  localparam int WIN_POS   = 3;
  // strobe phase timing
  localparam int STROBE_NS = 50;
  localparam int CLK_NS    = 5;
  localparam logic [3:0] STROBE_CYC = 4'((STROBE_NS + CLK_NS - 1) / CLK_NS);
endpackage
`default_nettype wire

// file: design/fcs_seq_rom.sv
// Purpose: holds the flash bus cycle list of each command sequence
// Assumes: read data registered, one cycle latency
// Notes:   step entry = {last, is_read, use_user_addr, use_user_data,
//          addr, data}
`default_nettype none
module fcs_seq_rom (
  // clock
  input  wire logic        ref_clk,
  input  wire logic        clk_en,
  // lookup
  input  wire logic [3:0]  op,
  input  wire logic [2:0]  step,
  output logic      [33:0] entry
);
  // one command step word
  function automatic logic [33:0] mk(input logic last, input logic rd,
    input logic ua, input logic ud, input logic [21:0] a,
    input logic [7:0] d);
    mk = {last, rd, ua, ud, a, d};
  endfunction

  // registered lookup of the step table
  always_ff @(posedge ref_clk) begin
    if (clk_en) begin
      if (step < 3'd2) begin
        // unlock pair leads the autoselect, program and erase sequences
        entry <= (step == 3'd0)
          ? mk(1'b0, 1'b0, 1'b0, 1'b0, fcs_pkg::UNLOCK_A1,
               fcs_pkg::UNLOCK_D1)
          : mk(1'b0, 1'b0, 1'b0, 1'b0, fcs_pkg::UNLOCK_A2,
               fcs_pkg::UNLOCK_D2);
      end else begin
        entry <= mk(1'b1, 1'b1, 1'b1, 1'b0, 22'h000000, 8'h00);
      end
      case (op)
        fcs_pkg::OP_READ:
          entry <= mk(1'b1, 1'b1, 1'b1, 1'b0, 22'h000000, 8'h00);
        // single reset write to any address
        fcs_pkg::OP_RESET:
          entry <= mk(1'b1, 1'b0, 1'b1, 1'b0, 22'h000000,
                      fcs_pkg::CD_RESET);
        fcs_pkg::OP_SUSPEND:
          entry <= mk(1'b1, 1'b0, 1'b1, 1'b0, 22'h000000,
                      fcs_pkg::CD_SUSP);
        fcs_pkg::OP_RESUME:
          entry <= mk(1'b1, 1'b0, 1'b1, 1'b0, 22'h000000,
                      fcs_pkg::CD_RESUME);
        fcs_pkg::OP_SECT_ADD:
          entry <= mk(1'b1, 1'b0, 1'b1, 1'b0, 22'h000000,
                      fcs_pkg::CD_SECT);
        fcs_pkg::OP_AUTOSEL: begin
          if (step == 3'd2)
            entry <= mk(1'b0, 1'b0, 1'b0, 1'b0, fcs_pkg::UNLOCK_A1,
                        fcs_pkg::CD_AUTO);
        end
        fcs_pkg::OP_PROGRAM: begin
          if (step == 3'd2)
            entry <= mk(1'b0, 1'b0, 1'b0, 1'b0, fcs_pkg::UNLOCK_A1,
                        fcs_pkg::CD_PROG);
          else if (step == 3'd3)
            entry <= mk(1'b1, 1'b0, 1'b1, 1'b1, 22'h000000, 8'h00);
        end
        fcs_pkg::OP_CHIP_ER, fcs_pkg::OP_SECT_ER: begin
          case (step)
            3'd2: entry <= mk(1'b0, 1'b0, 1'b0, 1'b0, fcs_pkg::UNLOCK_A1,
                              fcs_pkg::CD_ERSET);
            3'd3: entry <= mk(1'b0, 1'b0, 1'b0, 1'b0, fcs_pkg::UNLOCK_A1,
                              fcs_pkg::UNLOCK_D1);
            3'd4: entry <= mk(1'b0, 1'b0, 1'b0, 1'b0, fcs_pkg::UNLOCK_A2,
                              fcs_pkg::UNLOCK_D2);
            3'd5: entry <= (op == fcs_pkg::OP_CHIP_ER)
              ? mk(1'b1, 1'b0, 1'b0, 1'b0, fcs_pkg::UNLOCK_A1,
                   fcs_pkg::CD_CHIP)
              : mk(1'b1, 1'b0, 1'b1, 1'b0, 22'h000000, fcs_pkg::CD_SECT);
            default: ;
          endcase
        end
        default: ;
      endcase
    end
  end
endmodule
`default_nettype wire

// file: tb/fcs_host_monitor.sv
// Purpose: pin and bus checks for the flash host
// Assumes: bound to fcs_host, one clock domain
// Notes:   write pulse is at least eight cycles long
`default_nettype none
module fcs_host_monitor #(
  parameter int ADDR_W = 22
) (
  // clock and reset
  input wire logic              ref_clk,
  input wire logic              rst_n,
  // bus answer
  input wire logic              hreadyout,
  input wire logic              hresp,
  // flash pins
  input wire logic [ADDR_W-1:0] flash_addr,
  input wire logic              chip_select_n,
  input wire logic              write_strobe_n,
  input wire logic              output_enable_n,
  input wire logic [7:0]        flash_dq_out,
  input wire logic              flash_dq_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  chk_zero_wait: assert property (hreadyout && !hresp)
    else $error("slave not ready or not okay");
  chk_strobe_excl: assert property (write_strobe_n || output_enable_n)
    else $error("write and read strobes low together");
  chk_we_cs: assert property (!write_strobe_n |-> !chip_select_n)
    else $error("write strobe without chip select");
  chk_addr_setup: assert property ($fell(write_strobe_n) |->
    !$past(chip_select_n) && $stable(flash_addr))
    else $error("address or select not set before write");
  chk_addr_hold: assert property (!write_strobe_n &&
    $past(!write_strobe_n) |-> $stable(flash_addr))
    else $error("address moved during write pulse");
  chk_data_hold: assert property ($rose(write_strobe_n) |->
    flash_dq_oe && $stable(flash_dq_out))
    else $error("write data not held over strobe rise");
  chk_read_float: assert property (!output_enable_n |-> !flash_dq_oe)
    else $error("host drives data during read");
  chk_pulse_len: assert property ($fell(write_strobe_n) |->
    !write_strobe_n [*8])
    else $error("write pulse too short");
  chk_cs_hold: assert property ($rose(write_strobe_n) |->
    !chip_select_n [*2])
    else $error("chip select released too early");
  cover property ($fell(write_strobe_n));
  cover property ($fell(output_enable_n));
  cover property ($rose(chip_select_n));
endmodule
bind fcs_host fcs_host_monitor #(.ADDR_W(ADDR_W)) u_fcs_host_monitor (
  .ref_clk(ref_clk), .rst_n(rst_n), .hreadyout(hreadyout), .hresp(hresp),
  .flash_addr(flash_addr), .chip_select_n(chip_select_n),
  .write_strobe_n(write_strobe_n), .output_enable_n(output_enable_n),
  .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe));
`default_nettype wire

// file: tb/fcs_flash_model.sv
// Purpose: behavioural byte-wide flash answering the host
// Assumes: strobes are levels, time ticks of 10 ns
// Notes:   released data lines show the inverse of the last byte
`default_nettype none
module fcs_flash_model #(
  parameter logic [7:0] MAKER   = 8'h6B, // arbitrary value
  parameter logic [7:0] PART    = 8'h2D, // arbitrary value
  parameter int         T_PROG  = 100,
  parameter int         T_ERASE = 200
) (
  // flash pins
  input  wire logic [21:0] flash_addr,
  input  wire logic        chip_select_n,
  input  wire logic        write_strobe_n,
  input  wire logic        output_enable_n,
  input  wire logic [7:0]  flash_dq_out,
  output logic      [7:0]  flash_dq_in,
  output logic             ready_busy_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  mem [int];          // programmed bytes, rest erased
  logic [21:0] a_lat, pa;          // write latch, program address
  logic [7:0]  pdat, dq, last = 0; // program byte, read byte
  logic [5:0]  sect;               // sector under erase
  int          st = 0, left = 0;   // sequence step, ticks to go
  bit          busy, ers, chip, susp, asel, tog;
  wire logic   we_n = write_strobe_n | chip_select_n;
  wire logic   rd_n = output_enable_n | chip_select_n;
  function automatic logic [7:0] rdm(logic [21:0] a);
    return mem.exists(a) ? mem[a] : 8'hFF;
  endfunction
  // address at later fall, data at earlier rise
  always @(negedge we_n) a_lat = flash_addr;
  always @(posedge we_n) step(a_lat, flash_dq_out);
  task automatic step(input logic [21:0] a, input logic [7:0] d);
    logic u1, u2;
    u1 = a[10:0] == 11'h555;
    u2 = a[10:0] == 11'h2AA;
    // suspend in sector erase, resume while suspended
    if (busy || susp) begin
      if (d == 8'hB0 && ers && !susp)
        {susp, busy} = 2'b10;
      else if (d == 8'h30 && susp)
        {susp, busy} = 2'b01;
    // reset back to array reads, mismatch back to step zero
    end else if (d == 8'hF0) begin
      {st, asel} = 0;
    end else case (st)
      0, 4: st = (u1 && d == 8'hAA) ? st + 1 : 0;
      1, 5: st = (u2 && d == 8'h55) ? st + 1 : 0;
      2: begin
        asel = asel | (u1 && d == 8'h90);
        st = !u1 ? 0 : d == 8'hA0 ? 3 : d == 8'h80 ? 4 : 0;
      end
      // program starts at last write rise
      3: begin
        {pa, pdat, busy, left, st} = {a, d, 1'b1, T_PROG, 32'd0};
      end
      default: begin
        chip = u1 && d == 8'h10;
        ers = d == 8'h30;
        {sect, busy, left, st} = {a[21:16], chip | ers, T_ERASE, 32'd0};
      end
    endcase
  endtask
  // bits only go from one to zero by programming
  always #10 if (busy && --left == 0) begin
    if (chip)
      mem.delete();
    else if (ers)
      for (int k = 0; k < 65536; k++) mem.delete({sect, 16'(k)});
    else
      mem[pa] = rdm(pa) & pdat;
    {busy, ers, chip} = 0;
  end
  // status when busy, codes in autoselect
  // window bit set in erase, second toggle in erased sector
  always @* dq = busy ? {(ers | chip) ? 1'b0 : ~pdat[7], tog, 1'b0,
      1'b0, ers | chip,
      tog & (chip | (ers && flash_addr[21:16] == sect)), 2'b00}
    : asel ? (flash_addr[1:0] == 2'h0 ? MAKER
    : flash_addr[1:0] == 2'h1 ? PART : 8'h00) : rdm(flash_addr);
  // toggle flips after each busy read
  always @(posedge rd_n) begin
    last = dq;
    tog = busy ? ~tog : tog;
  end
  assign flash_dq_in = rd_n ? ~last : dq;
  assign ready_busy_n = ~busy;
endmodule
`default_nettype wire

// file: tb/fcs_host_tb_top.sv
// Purpose: self-checking bench for the flash host
// Assumes: zero-wait slave, flash model on the far side
// Notes:   expected bytes kept in a local associative array
`default_nettype none
module fcs_host_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] MAKER = 8'h6B; // arbitrary value
  localparam logic [7:0] PART  = 8'h2D; // arbitrary value
  logic        ref_clk = 0, rst_n = 0, hsel = 0, hwrite = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 0;
  logic        hreadyout, hresp, cs_n, we_n, oe_n, dq_oe, rb_n;
  logic [21:0] fa;
  logic [7:0]  dq_o, dq_i;
  logic [7:0]  exp_mem [int];   // bench copy of flash contents
  int          failures = 0, tests_run = 0, cycles = 0;
  fcs_host u_fcs_host (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(1'b1),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .flash_addr(fa), .chip_select_n(cs_n), .write_strobe_n(we_n),
    .output_enable_n(oe_n), .flash_dq_out(dq_o), .flash_dq_oe(dq_oe),
    .flash_dq_in(dq_i), .ready_busy_n(rb_n));
  fcs_flash_model #(.MAKER(MAKER), .PART(PART)) u_fcs_flash_model (
    .flash_addr(fa), .chip_select_n(cs_n), .write_strobe_n(we_n),
    .output_enable_n(oe_n), .flash_dq_out(dq_o), .flash_dq_in(dq_i),
    .ready_busy_n(rb_n));
  // 200 MHz clock and hang guard
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (++cycles == 60000) begin
    failures++;
    report_and_stop();
  end
  function automatic logic [7:0] emem(int a);
    return exp_mem.exists(a) ? exp_mem[a] : 8'hFF;
  endfunction
  task automatic check(string nm, logic [7:0] e, logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one single transfer, address then data phase
  task automatic ahb(logic wr, logic [7:0] a, logic [31:0] d);
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    hsize <= 3'b010;
    hsel <= 1'b1;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic poll(int b);
    int n;
    n = 0;
    do begin
      ahb(1'b0, fcs_pkg::REG_STATUS, 32'h0);
      n++;
    end while (rd[b] !== 1'b0 && n < 2000);
  endtask
  task automatic run(logic [3:0] op, logic [21:0] a, logic [7:0] d);
    ahb(1'b1, fcs_pkg::REG_ADDR, {10'h0, a});
    ahb(1'b1, fcs_pkg::REG_DATA, {24'h0, d});
    ahb(1'b1, fcs_pkg::REG_CMD, {28'h0, op});
    poll(0);
    if (op == fcs_pkg::OP_READ || op == fcs_pkg::OP_AUTOSEL)
      ahb(1'b0, fcs_pkg::REG_RDATA, 32'h0);
  endtask
  task automatic report_and_stop();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    logic [21:0] pa;
    logic [7:0]  pd, t1;
    void'($urandom(57));
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    check("hresp", 8'h0, {7'h0, hresp});
    repeat (3) begin
      pa = 22'($urandom());
      pd = 8'($urandom());
      exp_mem[pa] = emem(pa) & pd;
      run(fcs_pkg::OP_PROGRAM, pa, pd);
      ahb(1'b0, fcs_pkg::REG_STATUS, 32'h0);
      check("busy", 8'h1, {7'h0, rd[4]});
      run(fcs_pkg::OP_READ, pa, 8'h00);
      check("poll", {7'h0, ~pd[7]}, {7'h0, rd[7]});
      t1 = rd[7:0];
      run(fcs_pkg::OP_READ, pa, 8'h00);
      check("toggle", {7'h0, ~t1[6]}, {7'h0, rd[6]});
      poll(4);
      run(fcs_pkg::OP_READ, pa, 8'h00);
      check("byte", emem(pa), rd[7:0]);
    end
    for (int i = 0; i < 3; i++) begin
      run(fcs_pkg::OP_AUTOSEL, 22'(i), 8'h00);
      check("code", i == 0 ? MAKER : i == 1 ? PART : 8'h00, rd[7:0]);
    end
    run(fcs_pkg::OP_RESET, 22'h0, 8'h00);
    run(fcs_pkg::OP_READ, pa, 8'h00);
    check("array", emem(pa), rd[7:0]);
    // sector erase with suspend and resume
    run(fcs_pkg::OP_SECT_ER, pa, 8'h00);
    run(fcs_pkg::OP_SECT_ADD, pa, 8'h00);
    ahb(1'b0, fcs_pkg::REG_STATUS, 32'h0);
    check("adding", 8'h1, {7'h0, rd[4]});
    run(fcs_pkg::OP_SUSPEND, 22'h0, 8'h00);
    ahb(1'b0, fcs_pkg::REG_STATUS, 32'h0);
    check("suspended", 8'h0, {7'h0, rd[4]});
    run(fcs_pkg::OP_RESUME, 22'h0, 8'h00);
    ahb(1'b0, fcs_pkg::REG_STATUS, 32'h0);
    check("resumed", 8'h1, {7'h0, rd[4]});
    poll(4);
    exp_mem.delete(pa);
    run(fcs_pkg::OP_READ, pa, 8'h00);
    check("sector", 8'hFF, rd[7:0]);
    run(fcs_pkg::OP_CHIP_ER, 22'h0, 8'h00);
    run(fcs_pkg::OP_READ, 22'h0, 8'h00);
    check("erase poll", 8'h0, {7'h0, rd[7]});
    run(fcs_pkg::OP_SUSPEND, 22'h0, 8'h00);
    ahb(1'b0, fcs_pkg::REG_STATUS, 32'h0);
    check("chip busy", 8'h1, {7'h0, rd[4]});
    poll(4);
    foreach (exp_mem[k]) begin
      run(fcs_pkg::OP_READ, 22'(k), 8'h00);
      check("erased", 8'hFF, rd[7:0]);
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
